//--- rtl/ihc_top.sv
/*
  Interrupt and halt controller: factor flags, masks, enable state, stack
  pointer gate, priority vector and halt state, with an AXI4-Lite slave.
  Assumes all event inputs are one-cycle pulses synchronous to I_CORE_CLK,
  clock taps are levels, and the core pulses acknowledge only while a
  request is shown.
*/
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module ihc_top
  import ihc_pkg::*;
(
  input  wire logic                  I_CORE_CLK,
  input  wire logic                  I_RST,
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0] I_AWADDR,
  input  wire logic                  I_AWVALID,
  output logic                       O_AWREADY,
  input  wire logic [31:0]           I_WDATA,
  input  wire logic [3:0]            I_WSTRB,
  input  wire logic                  I_WVALID,
  output logic                       O_WREADY,
  output logic [1:0]                 O_BRESP,
  output logic                       O_BVALID,
  input  wire logic                  I_BREADY,
  input  wire logic [AXI_ADDR_W-1:0] I_ARADDR,
  input  wire logic                  I_ARVALID,
  output logic                       O_ARREADY,
  output logic [31:0]                O_RDATA,
  output logic [1:0]                 O_RRESP,
  output logic                       O_RVALID,
  input  wire logic                  I_RREADY,
  // Event sources
  input  wire logic [1:0]            I_PTIMER_ZERO,
  input  wire logic                  I_SERIAL_DONE,
  input  wire logic                  I_KEYGRP0_EDGE,
  input  wire logic                  I_KEYGRP1_EDGE,
  input  wire logic                  I_KEYGRP2_EDGE,
  input  wire logic [3:0]            I_CLK_TAPS,
  input  wire logic                  I_CONV_DONE,
  input  wire logic                  I_WDT_EVENT,
  // CPU core side
  input  wire logic                  I_SP_FIRST_WR,
  input  wire logic                  I_SP_SECOND_WR,
  input  wire logic                  I_IE_SET,
  input  wire logic                  I_IE_CLR,
  input  wire logic                  I_RETURN_FROM_IRQ,
  input  wire logic                  I_HALT_EXEC,
  input  wire logic                  I_IRQ_ACK,
  output logic                       O_IRQ_REQ,
  output logic [VEC_W-1:0]           O_IRQ_VECTOR,
  output logic                       O_ACCEPT,
  output logic                       O_CPU_HALTED,
  output logic                       O_IRQ
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] mask_nib(input ihc_src_type s, input logic [15:0] idx);
    logic [3:0] r;
    r = 4'h0;
    case (idx)
      IDX_PT_FLG:  r = {2'h0, s.ptimer};
      IDX_SER_FLG: r = {3'h0, s.serial};
      IDX_K0_FLG:  r = {3'h0, s.keygrp0};
      IDX_K12_FLG: r = {2'h0, s.keygrp2, s.keygrp1};
      IDX_CT_FLG:  r = s.clktap;
      IDX_AD_FLG:  r = {3'h0, s.conv};
      default:     r = 4'h0;
    endcase
    return r;
  endfunction

  // Spread one written nibble over the source fields of one register
  function automatic ihc_src_type nib_to_src(input logic [3:0] d, input logic [15:0] idx);
    ihc_src_type r;
    r = SRC_RESET;
    case (idx)
      IDX_PT_FLG:  r.ptimer = d[1:0];
      IDX_SER_FLG: r.serial = d[0];
      IDX_K0_FLG:  r.keygrp0 = d[0];
      IDX_K12_FLG: begin
        r.keygrp1 = d[0];
        r.keygrp2 = d[1];
      end
      IDX_CT_FLG:  r.clktap = d;
      IDX_AD_FLG:  r.conv = d[0];
      default:     r = SRC_RESET;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ihc_src_type              flags;
  ihc_src_type              masks;
  ihc_src_type              next_flags;
  ihc_src_type              flag_set;
  ihc_src_type              flag_clr;
  ihc_src_type              mask_wr;
  ihc_src_type              mask_sel;
  ihc_src_type              pend;
  logic                     irq_enable_state;
  logic                     nmi_pending;
  logic                     sp_first_seen;
  logic                     sp_second_seen;
  logic                     gate_open;
  logic [3:0]               taps_prev;
  logic [EVT_W-1:0]         evt_stat;
  logic [EVT_W-1:0]         evt_mask;
  logic [EVT_W-1:0]         evt_set;
  logic                     aw_held;
  logic                     w_held;
  logic [IDX_W-1:0]         aw_idx;
  logic [3:0]               w_nib;
  logic                     wr_go;
  logic                     wr_hit;
  logic [IDX_W-1:0]         ar_idx;
  logic [31:0]              rd_word;
  logic                     rd_hit;
  logic                     next_req;
  logic                     maskable_req;
  logic [VEC_W-1:0]         next_vec;
  logic                     accept;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Both beats held until the response is taken: one write at a time.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_AWREADY <= 1'b1;
      O_WREADY  <= 1'b1;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_idx    <= '0;
      w_nib     <= 4'h0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_held   <= 1'b1;
        O_AWREADY <= 1'b0;
        aw_idx    <= I_AWADDR[AXI_ADDR_W-1:2];
      end
      if (I_WVALID && O_WREADY) begin
        w_held   <= 1'b1;
        O_WREADY <= 1'b0;
        w_nib    <= I_WDATA[3:0] & {4{I_WSTRB[0]}};
      end
      if (wr_go) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID  <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY  <= 1'b1;
      end
    end
  end

  assign wr_go = aw_held && w_held && !O_BVALID;

  always_comb begin
    wr_hit   = 1'b1;
    flag_clr = SRC_RESET;
    mask_wr  = SRC_RESET;
    mask_sel = SRC_RESET;
    if (aw_idx >= IDX_FLAG_BASE && aw_idx <= IDX_AD_FLG) begin
      flag_clr = nib_to_src(w_nib, aw_idx);
    end else if (aw_idx >= IDX_PT_EN && aw_idx <= IDX_CT_EN) begin
      mask_wr  = nib_to_src(w_nib, aw_idx + IDX_MASK_GAP);
      mask_sel = nib_to_src(4'hf, aw_idx + IDX_MASK_GAP);
    end else if (aw_idx != IDX_CTRL && aw_idx != IDX_EVT_STAT && aw_idx != IDX_EVT_MASK &&
                 aw_idx != IDX_STATE) begin
      wr_hit = 1'b0;
    end
    if (!wr_go) begin
      flag_clr = SRC_RESET;
      mask_sel = SRC_RESET;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    if (ar_idx >= IDX_FLAG_BASE && ar_idx <= IDX_AD_FLG) begin
      rd_word[3:0] = mask_nib(flags, ar_idx);
    end else if (ar_idx >= IDX_PT_EN && ar_idx <= IDX_CT_EN) begin
      rd_word[3:0] = mask_nib(masks, ar_idx + IDX_MASK_GAP);
    end else begin
      case (ar_idx)
        IDX_CTRL:     rd_word[1:0] = {masks.conv, irq_enable_state};
        IDX_STATE:    rd_word[2:0] = {nmi_pending, O_CPU_HALTED, gate_open};
        IDX_EVT_STAT: rd_word[EVT_W-1:0] = evt_stat;
        IDX_EVT_MASK: rd_word[EVT_W-1:0] = evt_mask;
        default:      rd_hit = 1'b0;
      endcase
    end
  end

  assign ar_idx = I_ARADDR[AXI_ADDR_W-1:2];

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0;
      O_RRESP   <= RESP_OKAY;
    end else begin
      if (I_ARVALID && O_ARREADY) begin
        O_ARREADY <= 1'b0;
        O_RVALID  <= 1'b1;
        O_RDATA   <= rd_word;
        O_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID  <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Factor flags and masks
  // ----------------------------------------------------------------
  always_comb begin
    flag_set         = SRC_RESET;
    flag_set.ptimer  = I_PTIMER_ZERO;
    flag_set.serial  = I_SERIAL_DONE;
    flag_set.keygrp0 = I_KEYGRP0_EDGE;
    flag_set.keygrp1 = I_KEYGRP1_EDGE;
    flag_set.keygrp2 = I_KEYGRP2_EDGE;
    flag_set.clktap  = taps_prev & ~I_CLK_TAPS;
    flag_set.conv    = I_CONV_DONE;
    // Set wins over a clear landing in the same cycle
    next_flags = (flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      flags     <= SRC_RESET;
      taps_prev <= 4'h0;
    end else begin
      flags     <= next_flags;
      taps_prev <= I_CLK_TAPS;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      masks <= SRC_RESET;
    end else begin
      masks <= (masks & ~mask_sel) | (mask_wr & mask_sel);
      // Converter enable lives in the control register
      if (wr_go && aw_idx == IDX_CTRL) begin
        masks.conv <= w_nib[CTRL_ADEN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable state, stack pointer gate, watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      irq_enable_state <= 1'b0;
    end else if (accept) begin
      irq_enable_state <= 1'b0;
    end else if (I_IE_SET || I_RETURN_FROM_IRQ) begin
      irq_enable_state <= 1'b1;
    end else if (I_IE_CLR) begin
      irq_enable_state <= 1'b0;
    end else if (wr_go && aw_idx == IDX_CTRL) begin
      irq_enable_state <= w_nib[CTRL_IE_BIT];
    end
  end

  // Closed from reset; opens only when both pointers have been written
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      gate_open      <= 1'b0;
      sp_first_seen  <= 1'b0;
      sp_second_seen <= 1'b0;
    end else if (I_SP_FIRST_WR && I_SP_SECOND_WR) begin
      gate_open      <= 1'b1;
      sp_first_seen  <= 1'b0;
      sp_second_seen <= 1'b0;
    end else if (I_SP_FIRST_WR) begin
      gate_open      <= sp_second_seen;
      sp_first_seen  <= !sp_second_seen;
      sp_second_seen <= 1'b0;
    end else if (I_SP_SECOND_WR) begin
      gate_open      <= sp_first_seen;
      sp_second_seen <= !sp_first_seen;
      sp_first_seen  <= 1'b0;
    end
  end

  // No factor flag for the watchdog; a latch, readable in the state register, holds it until taken
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      nmi_pending <= 1'b0;
    end else if (I_WDT_EVENT) begin
      nmi_pending <= 1'b1;
    end else if (accept && O_IRQ_VECTOR == VEC_WDT) begin
      nmi_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Request, priority and vector
  // ----------------------------------------------------------------
  always_comb begin
    pend         = flags & masks;
    maskable_req = irq_enable_state && (|pend);
    next_vec     = VEC_CONV;
    if (nmi_pending) begin
      next_vec = VEC_WDT;
    end else if (|pend.ptimer) begin
      next_vec = VEC_PTIMER;
    end else if (pend.serial) begin
      next_vec = VEC_SERIAL;
    end else if (pend.keygrp0) begin
      next_vec = VEC_KEY0;
    end else if (pend.keygrp1 || pend.keygrp2) begin
      next_vec = VEC_KEY12;
    end else if (|pend.clktap) begin
      next_vec = VEC_CLKTMR;
    end
    // Dropped in the acknowledge cycle so one request is taken once
    next_req = gate_open && (nmi_pending || maskable_req) && !accept;
  end

  assign accept = I_IRQ_ACK && O_IRQ_REQ;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_IRQ_REQ    <= 1'b0;
      O_IRQ_VECTOR <= VEC_WDT;
      O_ACCEPT     <= 1'b0;
    end else begin
      O_IRQ_REQ    <= next_req;
      // Vector held only in the cycle an acknowledge is taken
      if (!O_IRQ_REQ || !accept) begin
        O_IRQ_VECTOR <= next_vec;
      end
      // Tells the core to save flags and push the return address
      O_ACCEPT     <= accept;
    end
  end

  // ----------------------------------------------------------------
  // Halt
  // ----------------------------------------------------------------
  // Only the core stops; the event sources keep running meanwhile.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_CPU_HALTED <= 1'b0;
    end else if (O_CPU_HALTED && next_req) begin
      O_CPU_HALTED <= 1'b0;
    end else if (I_HALT_EXEC) begin
      O_CPU_HALTED <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Block event status and interrupt line
  // ----------------------------------------------------------------
  always_comb begin
    evt_set             = '0;
    evt_set[EVT_ACCEPT] = accept;
    evt_set[EVT_WAKE]   = O_CPU_HALTED && next_req;
    evt_set[EVT_NMI]    = I_WDT_EVENT;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      evt_stat <= '0;
    end else if (wr_go && aw_idx == IDX_EVT_STAT) begin
      evt_stat <= (evt_stat & ~w_nib[EVT_W-1:0]) | evt_set;
    end else begin
      evt_stat <= evt_stat | evt_set;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      evt_mask <= '0;
    end else if (wr_go && aw_idx == IDX_EVT_MASK) begin
      evt_mask <= w_nib[EVT_W-1:0];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(evt_stat & evt_mask);
    end
  end

endmodule // ihc_top

//--- rtl/ihc_pkg.sv
/*
  Constants, register indices, field layout and vectors for the interrupt and
  halt controller. Assumes a 32-bit AXI4-Lite master reaching each register
  index at byte address four times that index.
*/
// Notes on behaviour
// - Maskable request needs enable state and mask
// - Acceptance clears the interrupt enable state
// - Watchdog request ignores enable state, no flag
// - After reset block all until both pointers
// - One pointer written blocks all until other
// - Halt stops core, timers keep counting
// - Any hardware request releases halt
// - Source event sets flag regardless of mask
// - Write one clears flag, reset reads zero
// - Timer channels set bits one and zero
// - Serial flag set on 8-bit transfer end
// - Key groups each set own flag
// - Clock taps falling edge set bits 3..0
// - Pending flag re-raises request when re-enabled
// - Masks read/write, one enables, reset zero
// - Mask sits 0x10 below flag, same bit; converter enable is control bit 1 instead
// - Acceptance saves flags, pushes return address
// - Vectors 0100H..010EH by fixed priority
package ihc_pkg;

  localparam int          AXI_ADDR_W    = 18;
  localparam int          IDX_W         = 16;
  localparam int          NIB_W         = 4;
  localparam int          VEC_W         = 16;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_FLAG_BASE = 16'hfff2;
  localparam logic [15:0] IDX_MASK_GAP  = 16'h0010;
  localparam logic [15:0] IDX_PT_EN     = 16'hffe2;
  localparam logic [15:0] IDX_SER_EN    = 16'hffe3;
  localparam logic [15:0] IDX_K0_EN     = 16'hffe4;
  localparam logic [15:0] IDX_K12_EN    = 16'hffe5;
  localparam logic [15:0] IDX_CT_EN     = 16'hffe6;
  localparam logic [15:0] IDX_PT_FLG    = 16'hfff2;
  localparam logic [15:0] IDX_SER_FLG   = 16'hfff3;
  localparam logic [15:0] IDX_K0_FLG    = 16'hfff4;
  localparam logic [15:0] IDX_K12_FLG   = 16'hfff5;
  localparam logic [15:0] IDX_CT_FLG    = 16'hfff6;
  localparam logic [15:0] IDX_AD_FLG    = 16'hfff7;
  localparam logic [15:0] IDX_CTRL      = 16'hffd0;
  localparam logic [15:0] IDX_STATE     = 16'hffd1;
  localparam logic [15:0] IDX_EVT_STAT  = 16'hffd2;
  localparam logic [15:0] IDX_EVT_MASK  = 16'hffd3;

  // Control register bits
  localparam int          CTRL_IE_BIT   = 0;
  localparam int          CTRL_ADEN_BIT = 1;
  // Event status bits
  localparam int          EVT_ACCEPT    = 0;
  localparam int          EVT_WAKE      = 1;
  localparam int          EVT_NMI       = 2;
  localparam int          EVT_W         = 3;

  localparam logic [3:0]  NIB_RESET     = 4'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  localparam logic [15:0] VEC_WDT       = 16'h0100;
  localparam logic [15:0] VEC_PTIMER    = 16'h0104;
  localparam logic [15:0] VEC_SERIAL    = 16'h0106;
  localparam logic [15:0] VEC_KEY0      = 16'h0108;
  localparam logic [15:0] VEC_KEY12     = 16'h010a;
  localparam logic [15:0] VEC_CLKTMR    = 16'h010c;
  localparam logic [15:0] VEC_CONV      = 16'h010e;

  typedef struct packed {
    logic [1:0] ptimer;
    logic       serial;
    logic       keygrp0;
    logic       keygrp1;
    logic       keygrp2;
    logic [3:0] clktap;
    logic       conv;
  } ihc_src_type;

  localparam ihc_src_type SRC_RESET = '0;

endpackage

//--- verification/ihc_chk.sv
/* Checker for ihc_top: bus handshakes, acceptance, halt and gate timing.
   Bound to ihc_top; sees only its ports. */
`timescale 1ns/1ps
module ihc_chk
  import ihc_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_WDT_EVENT,
  input wire logic I_SP_FIRST_WR,
  input wire logic I_SP_SECOND_WR,
  input wire logic I_HALT_EXEC,
  input wire logic I_IRQ_ACK,
  input wire logic O_IRQ_REQ,
  input wire logic O_ACCEPT,
  input wire logic O_CPU_HALTED
);
  logic sp1_seen;
  logic sp2_seen;
  logic gate_ok;
  assign gate_ok = sp1_seen & sp2_seen;
  // Shadow gate; a lone pointer write recloses it
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sp1_seen <= 1'b0;
      sp2_seen <= 1'b0;
    end else if (I_SP_FIRST_WR) begin
      sp1_seen <= 1'b1;
      sp2_seen <= I_SP_SECOND_WR | (sp2_seen & ~gate_ok);
    end else if (I_SP_SECOND_WR) begin
      sp2_seen <= 1'b1;
      sp1_seen <= sp1_seen & ~gate_ok;
    end
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  sequence s_wr_taken;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_wr_resp;
    !O_AWREADY && !O_BVALID ##1 O_BVALID;
  endsequence
  sequence s_nmi_open;
    gate_ok && I_WDT_EVENT ##1 gate_ok [*2];
  endsequence
  wr_resp_a: assert property (s_wr_taken |=> s_wr_resp) else $error("write response timing wrong");
  bresp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID) else $error("write response dropped early");
  rd_resp_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY) else $error("read data late");
  ack_clear_a: assert property (O_IRQ_REQ && I_IRQ_ACK |=> O_ACCEPT && !O_IRQ_REQ) else $error("ack not taken");
  accept_once_a: assert property (O_ACCEPT |=> !O_ACCEPT) else $error("accept pulse too long");
  accept_cause_a: assert property ($rose(O_ACCEPT) |-> $past(O_IRQ_REQ) && $past(I_IRQ_ACK))
    else $error("accept without ack");
  halt_cause_a: assert property ($rose(O_CPU_HALTED) |-> $past(I_HALT_EXEC)) else $error("halt without cause");
  wake_req_a: assert property ($rose(O_IRQ_REQ) |-> !O_CPU_HALTED) else $error("request while halted");
  wake_cause_a: assert property ($fell(O_CPU_HALTED) && !$past(I_RST) |-> $rose(O_IRQ_REQ))
    else $error("wake without request");
  gate_block_a: assert property (!gate_ok && !$past(gate_ok) |-> !O_IRQ_REQ) else $error("request while gated");
  nmi_req_a: assert property (s_nmi_open |-> ##[0:1] O_IRQ_REQ) else $error("watchdog request missing");
endmodule // ihc_chk

bind ihc_top ihc_chk u_chk (.I_CORE_CLK, .I_RST, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID,
  .I_BREADY, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_WDT_EVENT, .I_SP_FIRST_WR, .I_SP_SECOND_WR,
  .I_HALT_EXEC, .I_IRQ_ACK, .O_IRQ_REQ, .O_ACCEPT, .O_CPU_HALTED);

//--- verification/ihc_cpu_model.sv
/* Core model: acknowledges a shown request after a set delay and logs it.
   Assumes the request stays up until acknowledged. */
`timescale 1ns/1ps
module ihc_cpu_model
  import ihc_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_irq_req,
  input  wire logic [VEC_W-1:0] i_irq_vector,
  input  wire logic [3:0]       i_ack_delay,
  output logic                  o_irq_ack,
  output logic [VEC_W-1:0]      o_taken_vec,
  output logic [7:0]            o_taken_cnt
);
  logic [3:0] wait_cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq_ack   <= 1'b0;
      o_taken_vec <= 16'h0000;
      o_taken_cnt <= 8'h00;
      wait_cnt    <= 4'h0;
    end else if (i_irq_req && !o_irq_ack && wait_cnt == i_ack_delay) begin
      o_irq_ack   <= 1'b1;
      o_taken_vec <= i_irq_vector;
      o_taken_cnt <= o_taken_cnt + 8'h01;
      wait_cnt    <= 4'h0;
    end else begin
      o_irq_ack <= 1'b0;
      wait_cnt  <= (i_irq_req && !o_irq_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // ihc_cpu_model

//--- verification/testbench.sv
/* Testbench for ihc_top: bus master, event pulses and core model.
   Assumes ihc_pkg, the checker and the core model are compiled first. */
`timescale 1ns/1ps
module testbench
  import ihc_pkg::*;
;
  localparam int P_PT0 = 0, P_SER = 2, P_K0 = 3, P_K1 = 4, P_K2 = 5, P_CONV = 6, P_WDT = 7;
  localparam int P_SP1 = 8, P_SP2 = 9, P_IES = 10, P_IEC = 11, P_RETURN_FROM_IRQ = 12, P_HALT = 13;
  localparam logic [15:0] MIDX [5] = '{IDX_PT_EN, IDX_SER_EN, IDX_K0_EN, IDX_K12_EN, IDX_CT_EN};
  localparam logic [3:0]  MBITS [6] = '{4'h3, 4'h1, 4'h1, 4'h3, 4'hf, 4'h1};
  localparam logic [15:0] VECS [6] = '{VEC_PTIMER, VEC_SERIAL, VEC_KEY0, VEC_KEY12, VEC_CLKTMR, VEC_CONV};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [13:0] ev = '0;
  logic [3:0]  taps = '0;
  logic [3:0]  ack_dly = '0;
  logic        awready, wready, bvalid, arready, rvalid, irq_req, accept, halted, irq, ack;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] vec, tvec;
  logic [7:0]  tcnt;
  int          error_cnt = 0;
  int          comparisons = 0;

  ihc_top DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_PTIMER_ZERO(ev[1:0]),
    .I_SERIAL_DONE(ev[2]), .I_KEYGRP0_EDGE(ev[3]), .I_KEYGRP1_EDGE(ev[4]), .I_KEYGRP2_EDGE(ev[5]),
    .I_CLK_TAPS(taps), .I_CONV_DONE(ev[6]), .I_WDT_EVENT(ev[7]), .I_SP_FIRST_WR(ev[8]),
    .I_SP_SECOND_WR(ev[9]), .I_IE_SET(ev[10]), .I_IE_CLR(ev[11]), .I_RETURN_FROM_IRQ(ev[12]),
    .I_HALT_EXEC(ev[13]), .I_IRQ_ACK(ack), .O_IRQ_REQ(irq_req), .O_IRQ_VECTOR(vec), .O_ACCEPT(accept),
    .O_CPU_HALTED(halted), .O_IRQ(irq));
  ihc_cpu_model u_cpu (.i_clk(clk), .i_rst(rst), .i_irq_req(irq_req), .i_irq_vector(vec),
    .i_ack_delay(ack_dly), .o_irq_ack(ack), .o_taken_vec(tvec), .o_taken_cnt(tcnt));

  initial begin
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("Mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int a, input int b = 99);
    logic [13:0] m;
    m = '0;
    m[a] = 1'b1;
    if (b < 14) m[b] = 1'b1;
    ev <= m;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask
  task automatic axi_wr(input logic [15:0] idx, input logic [3:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    awaddr <= {idx, 2'b00};
    wdata <= {28'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Ready left high between writes; waits end only by the watchdog
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check(32'(n < 40), 32'h1);
    check(bresp, er);
  endtask
  task automatic axi_rd(input logic [15:0] idx, input logic [3:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    check(32'(n < 40), 32'h1);
    check(rdata, {28'h0, d});
    check(rresp, er);
  endtask
  task automatic expect_irq(input logic [15:0] v);
    logic [7:0] c0;
    c0 = tcnt;
    for (int n = 0; n < 40 && tcnt == c0; n++) @(posedge clk);
    check(tcnt, c0 + 8'h01);
    check(tvec, v);
  endtask
  task automatic expect_none;
    logic [7:0] c0;
    c0 = tcnt;
    tick(12);
    check(tcnt, c0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 5; i++) begin
      axi_rd(MIDX[i], 4'h0);
      axi_rd(MIDX[i] + IDX_MASK_GAP, 4'h0);
      axi_wr(MIDX[i], 4'hf);
      axi_rd(MIDX[i], MBITS[i]);
      axi_wr(MIDX[i], 4'h0);
    end
    axi_rd(IDX_AD_FLG, 4'h0);
    axi_rd(16'h0000, 4'h0, RESP_SLVERR);
    axi_wr(16'h0000, 4'hf, RESP_SLVERR);
  endtask
  task automatic t_gate;
    pulse(P_WDT);
    expect_none;
    pulse(P_SP1);
    expect_none;
    axi_rd(IDX_STATE, 4'h4);
    pulse(P_SP2);
    expect_irq(VEC_WDT);
    pulse(P_SP2);
    pulse(P_WDT);
    expect_none;
    pulse(P_SP1);
    expect_irq(VEC_WDT);
  endtask
  task automatic t_mask_ie;
    pulse(1);
    axi_rd(IDX_PT_FLG, 4'h2);
    axi_wr(IDX_CTRL, 4'h1);
    expect_none;
    ack_dly <= 4'h5;
    axi_wr(IDX_PT_EN, 4'h2);
    expect_irq(VEC_PTIMER);
    axi_rd(IDX_CTRL, 4'h0);
    expect_none;
    pulse(P_RETURN_FROM_IRQ);
    expect_irq(VEC_PTIMER);
    axi_wr(IDX_PT_FLG, 4'h0);
    axi_rd(IDX_PT_FLG, 4'h2);
    axi_wr(IDX_PT_FLG, 4'h2);
    axi_rd(IDX_PT_FLG, 4'h0);
    pulse(P_IES);
    expect_none;
  endtask
  task automatic t_sources;
    ack_dly <= 4'h0;
    pulse(P_IEC);
    pulse(P_SER, P_K0);
    pulse(P_K1, P_K2);
    pulse(P_PT0, P_CONV);
    // Uneven tap pattern so a swapped bit order shows up
    taps <= 4'h5;
    tick(2);
    taps <= 4'h0;
    tick(2);
    for (int i = 0; i < 5; i++) begin
      axi_rd(MIDX[i] + IDX_MASK_GAP, MBITS[i] & ((i == 0) ? 4'h1 : (i == 4) ? 4'h5 : 4'hf));
    end
    for (int i = 0; i < 5; i++) axi_wr(MIDX[i], MBITS[i]);
    axi_wr(IDX_CTRL, 4'h3);
    for (int i = 0; i < 6; i++) begin
      expect_irq(VECS[i]);
      axi_wr(IDX_PT_FLG + 16'(i), MBITS[i]);
      pulse(P_IES);
    end
    expect_none;
  endtask
  task automatic t_halt;
    pulse(P_HALT);
    check(halted, 1'b1);
    pulse(P_PT0);
    expect_irq(VEC_PTIMER);
    check(halted, 1'b0);
    axi_wr(IDX_PT_FLG, 4'h1);
    pulse(P_HALT);
    check(halted, 1'b1);
    pulse(P_WDT);
    expect_irq(VEC_WDT);
    check(halted, 1'b0);
    axi_rd(IDX_EVT_STAT, 4'h7);
    axi_wr(IDX_EVT_MASK, 4'h1);
    tick(3);
    check(irq, 1'b1);
    axi_wr(IDX_EVT_STAT, 4'h7);
    tick(3);
    check(irq, 1'b0);
  endtask
  task automatic t_rerun;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    axi_rd(IDX_CT_EN, 4'h0);
    pulse(P_WDT);
    expect_none;
  endtask

  initial begin
    tick(2);
    rst <= 1'b0;
    t_regs();
    t_gate();
    t_mask_ie();
    t_sources();
    t_halt();
    t_rerun();
    final_report();
  end
  // Whole run is a few hundred cycles
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end
endmodule // testbench
